// ---- drcs_partner.sv ----
// Terminal switches, keypads and motor ramp facing the selector.
module drcs_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Settings from the bench
  input wire logic [7:0] setTerm,
  input wire logic [3:0] setKeys,
  input wire logic setRemote,
  input wire logic setNeg,
  input wire logic setFault,
  // Drive feedback
  input wire logic runOut,
  // Levels toward the selector
  output logic [7:0] terminals,
  output logic [3:0] keys,
  output logic remoteConnected,
  output logic bipolarNegative,
  output logic faultActive,
  output logic motorStopped
);
  logic [2:0] speed;
  // Contacts move just after an edge; an unplugged remote presses nothing
  always_ff @(posedge mclk) begin
    terminals <= setTerm;
    keys <= setRemote ? setKeys : (setKeys & 4'h3);
    remoteConnected <= setRemote;
    bipolarNegative <= setNeg;
    faultActive <= setFault;
  end
  // Motor needs several cycles to coast down, so reversal must wait
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      speed <= 3'h0;
    else if (runOut && speed != 3'h6)
      speed <= speed + 3'h1;
    else if (!runOut && speed != 3'h0)
      speed <= speed - 3'h1;
  end
  assign motorStopped = (speed == 3'h0);
endmodule // drcs_partner

// ---- drcs_pkg.sv ----
// Constants, register map and types for the drive run command selector.
// How it works
// - Terminals eight, seven, six form step index bits 2..0 while running.
// - Index 0 uses frequency command; 1-3 and 4-7 use step registers.
// - Source 0: keypad run key starts if frequency set; stop key stops.
// - Keypad mode direction comes from keypad direction select, F forward, r reverse.
// - Built-in keypad is ignored while a remote keypad is connected.
// - Source 1: terminal one requests forward, terminal two requests reverse.
// - Source 1: both run terminals on together stops the motor.
// - Source 2: terminal one runs, terminal two selects direction, on is reverse.
// - Source 3: run commands come from serial link with its configuration.
// - Frequency source 2: negative bipolar voltage inverts commanded direction.
// - Polarity flip while running: decelerate to stop, then run opposite.
// - Run inhibit: 0 allows both, 1 blocks forward, 2 blocks reverse.
// - Power-on start is read at the first edge after reset, while its bit still holds reset value 0, so a held run terminal never starts.
// - Restart-after-fault with terminal source and run terminal on restarts on clear.
// - Automatic start and restart do nothing for keypad or serial sources.
package drcs_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIR = 8'h04;
  localparam logic [7:0] REG_AUTO = 8'h08;
  localparam logic [7:0] REG_LINKCFG = 8'h0c;
  localparam logic [7:0] REG_TERMFUNC = 8'h10;
  localparam logic [7:0] REG_LINKRUN = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_STEP_BASE = 8'h40;
  localparam logic [7:0] REG_STEP_MASK = 8'he0;
  // Command and frequency source codes
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERM1 = 2'h1;
  localparam logic [1:0] SRC_TERM2 = 2'h2;
  localparam logic [1:0] SRC_LINK = 2'h3;
  localparam logic [3:0] FRQ_BIPOLAR = 4'h2;
  // Run inhibit codes
  localparam logic [1:0] INH_FWD = 2'h1;
  localparam logic [1:0] INH_REV = 2'h2;
  // Terminal function codes
  localparam logic [4:0] FUNC_FWD = 5'h00;
  localparam logic [4:0] FUNC_REV = 5'h01;
  localparam logic [4:0] FUNC_STEP0 = 5'h05;
  localparam logic [4:0] FUNC_STEP1 = 5'h06;
  localparam logic [4:0] FUNC_STEP2 = 5'h07;
  localparam int FUNC_W = 5;
  // Terminal positions on the terminal input bus
  localparam int TERM_ONE = 0;
  localparam int TERM_TWO = 1;
  localparam int TERM_SIX = 5;
  localparam int TERM_SEVEN = 6;
  localparam int TERM_EIGHT = 7;
  // Field positions
  localparam int CTRL_FRQ_LSB = 4;
  localparam int DIR_INH_LSB = 4;
  localparam int AUTO_RESTART = 1;
  localparam int LINK_STATION_LSB = 8;
  localparam int LINK_BAUD_LSB = 16;
  localparam int TF_TWO_LSB = 5;
  localparam int TF_SIX_LSB = 10;
  localparam int TF_SEVEN_LSB = 15;
  localparam int TF_EIGHT_LSB = 20;
  localparam int ST_DIR = 1;
  localparam int ST_REVERSING = 2;
  localparam int ST_STEP_LSB = 4;
  localparam int ST_NEED_EDGE = 8;
  localparam int ST_FAULT = 9;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] DIR_RST = 32'h0000_0000;
  localparam logic [31:0] AUTO_RST = 32'h0000_0000;
  localparam logic [31:0] LINKCFG_RST = 32'h0003_0100;
  localparam logic [31:0] TERMFUNC_RST = 32'h0073_1420;
  // Step frequency table
  localparam int STEP_AW = 3;
  localparam int STEP_DW = 16;
  localparam int STEP_WORDS = 8;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_REVERSE} drcs_state_t;
endpackage

// ---- drcs_properties.sv ----
// Port properties of the run command selector, bound to its top module.
module drcs_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Inputs and run outputs
  input wire logic [7:0] terminals,
  input wire logic faultActive,
  input wire logic runOut,
  input wire logic dirRevOut,
  input wire logic [drcs_pkg::STEP_AW-1:0] stepIndex
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Bus answer comes two edges after the request, one cycle wide
  chk_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |->
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o)
    else $error("bus answer not two cycles after request");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i, 2) && $past(wb_stb_i, 2))
    else $error("bus answer without request");
  // Read data only moves with a read answer
  chk_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  // Nothing runs straight out of reset
  chk_reset_quiet: assert property ($fell(rst) |->
    !runOut && !dirRevOut && stepIndex == 3'h0 && !wb_ack_o)
    else $error("outputs active right after reset");
  chk_fault_stop: assert property (faultActive |=> !runOut)
    else $error("run held during a fault");
  // Direction may only turn after the run has dropped
  chk_dir_locked: assert property (runOut ##1 runOut |-> $stable(dirRevOut))
    else $error("direction changed while running");
  chk_step_follow: assert property (runOut |-> stepIndex == 3'($past(terminals) >> 5))
    else $error("step index differs from terminals");
endmodule // drcs_properties

bind drcs_top drcs_properties drcs_properties_i (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .terminals(terminals),
  .faultActive(faultActive), .runOut(runOut), .dirRevOut(dirRevOut), .stepIndex(stepIndex)
);

// ---- drcs_step_if.sv ----
// Carrier between the selector and its step frequency table.
interface drcs_step_if;
  logic wrEn;
  logic [drcs_pkg::STEP_AW-1:0] wrAddr;
  logic [drcs_pkg::STEP_DW-1:0] wrData;
  logic [drcs_pkg::STEP_AW-1:0] rdAddr;
  logic [drcs_pkg::STEP_DW-1:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ---- drcs_step_mem.sv ----
// Eight-word step frequency table with registered read data.
module drcs_step_mem (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Table access
  drcs_step_if.mem port
);
  logic [drcs_pkg::STEP_DW-1:0] words [drcs_pkg::STEP_WORDS];

  // Table contents, cleared so index 0 starts as zero frequency
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < drcs_pkg::STEP_WORDS; i++) begin
        words[i] <= '0;
      end
    end else if (port.wrEn) begin
      words[port.wrAddr] <= port.wrData;
    end
  end

  // Registered read port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port.rdData <= '0;
    end else begin
      port.rdData <= words[port.rdAddr];
    end
  end
endmodule // drcs_step_mem

// ---- drcs_top.sv ----
// Run command selector: source decoding, direction, inhibit, auto start, bus.
module drcs_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Terminals and keypads
  input wire logic [7:0] terminals,
  input wire logic localRunKey,
  input wire logic localStopKey,
  input wire logic remoteRunKey,
  input wire logic remoteStopKey,
  input wire logic remoteConnected,
  // Drive state
  input wire logic bipolarNegative,
  input wire logic faultActive,
  input wire logic motorStopped,
  // Run outputs
  output logic runOut,
  output logic dirRevOut,
  output logic [drcs_pkg::STEP_AW-1:0] stepIndex,
  output logic [drcs_pkg::STEP_DW-1:0] freqRef
);
  // Terminal active when on and programmed to the given function
  function automatic logic termIs(input logic on, input logic [4:0] func,
                                  input logic [4:0] code);
    return on && (func == code);
  endfunction

  // Byte-lane merge for partial writes
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  drcs_step_if stepBus ();

  drcs_step_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .port(stepBus.mem)
  );

  logic [31:0] ctrlReg;
  logic [31:0] dirReg;
  logic [31:0] autoReg;
  logic [31:0] linkCfgReg;
  logic [31:0] termFuncReg;
  logic [31:0] linkRunReg;
  logic pend;
  logic busRdLast;
  logic step0Set;
  logic powerUp;
  logic faultLast;
  logic needEdge;
  logic keypadRun;
  drcs_pkg::drcs_state_t state;
  logic [1:0] cmdSource;
  logic [3:0] freqSource;
  logic [1:0] runInhibit;
  logic srcTerm;
  logic fwdRunInput;
  logic revRunInput;
  logic [2:0] termStep;
  logic termRun;
  logic wantRun;
  logic wantRev;
  logic allowed;
  logic busStart;
  logic busWrite;
  logic stepHit;
  logic [31:0] wrMerged;

  // Configuration fields
  assign cmdSource = ctrlReg[1:0];
  assign freqSource = ctrlReg[drcs_pkg::CTRL_FRQ_LSB +: 4];
  assign runInhibit = dirReg[drcs_pkg::DIR_INH_LSB +: 2];
  assign srcTerm = (cmdSource == drcs_pkg::SRC_TERM1) || (cmdSource == drcs_pkg::SRC_TERM2);

  // Terminal decode through the programmed function codes
  assign fwdRunInput = termIs(terminals[drcs_pkg::TERM_ONE],
                              termFuncReg[drcs_pkg::FUNC_W-1:0], drcs_pkg::FUNC_FWD);
  assign revRunInput = termIs(terminals[drcs_pkg::TERM_TWO],
                              termFuncReg[drcs_pkg::TF_TWO_LSB +: drcs_pkg::FUNC_W],
                              drcs_pkg::FUNC_REV);
  assign termStep[2] = termIs(terminals[drcs_pkg::TERM_EIGHT],
                              termFuncReg[drcs_pkg::TF_EIGHT_LSB +: drcs_pkg::FUNC_W],
                              drcs_pkg::FUNC_STEP2);
  assign termStep[1] = termIs(terminals[drcs_pkg::TERM_SEVEN],
                              termFuncReg[drcs_pkg::TF_SEVEN_LSB +: drcs_pkg::FUNC_W],
                              drcs_pkg::FUNC_STEP1);
  assign termStep[0] = termIs(terminals[drcs_pkg::TERM_SIX],
                              termFuncReg[drcs_pkg::TF_SIX_LSB +: drcs_pkg::FUNC_W],
                              drcs_pkg::FUNC_STEP0);

  // Run terminal of the selected scheme; scheme 2 runs on the forward terminal only
  assign termRun = (cmdSource == drcs_pkg::SRC_TERM1) ? (fwdRunInput ^ revRunInput)
                                                       : fwdRunInput;

  // Run and direction request from the selected source
  always_comb begin
    wantRun = 1'b0;
    wantRev = 1'b0;
    unique case (cmdSource)
      drcs_pkg::SRC_KEYPAD: begin
        wantRun = keypadRun;
        wantRev = dirReg[0];
      end
      drcs_pkg::SRC_TERM1: begin
        wantRun = termRun && !needEdge;
        wantRev = revRunInput && !fwdRunInput;
      end
      drcs_pkg::SRC_TERM2: begin
        wantRun = termRun && !needEdge;
        wantRev = revRunInput;
      end
      drcs_pkg::SRC_LINK: begin
        wantRun = linkRunReg[0];
        wantRev = linkRunReg[1];
      end
    endcase
    // Bipolar reference inverts direction whatever the source
    if (freqSource == drcs_pkg::FRQ_BIPOLAR && bipolarNegative) begin
      wantRev = !wantRev;
    end
  end

  // Inhibit blocks the requested direction only
  assign allowed = !((!wantRev && runInhibit == drcs_pkg::INH_FWD) ||
                     (wantRev && runInhibit == drcs_pkg::INH_REV));

  // Bus request decode
  assign busStart = wb_cyc_i && wb_stb_i && !pend && !wb_ack_o;
  // Write lands at the edge the master samples ack, never earlier
  assign busWrite = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign stepHit = (wb_adr_i & drcs_pkg::REG_STEP_MASK) == drcs_pkg::REG_STEP_BASE;

  // Merge source chosen by address, so partial writes to the six configuration registers keep untouched lanes
  always_comb begin
    wrMerged = '0;
    unique case (wb_adr_i)
      drcs_pkg::REG_CTRL: wrMerged = mergeBytes(ctrlReg, wb_dat_i, wb_sel_i);
      drcs_pkg::REG_DIR: wrMerged = mergeBytes(dirReg, wb_dat_i, wb_sel_i);
      drcs_pkg::REG_AUTO: wrMerged = mergeBytes(autoReg, wb_dat_i, wb_sel_i);
      drcs_pkg::REG_LINKCFG: wrMerged = mergeBytes(linkCfgReg, wb_dat_i, wb_sel_i);
      drcs_pkg::REG_TERMFUNC: wrMerged = mergeBytes(termFuncReg, wb_dat_i, wb_sel_i);
      drcs_pkg::REG_LINKRUN: wrMerged = mergeBytes(linkRunReg, wb_dat_i, wb_sel_i);
      default: wrMerged = wb_dat_i;
    endcase
  end

  // Bus handshake: pend on first cycle, ack on the second, drop after
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      pend <= busStart;
      wb_ack_o <= pend && !wb_ack_o;
    end
  end

  // Configuration registers, written at the acknowledging edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlReg <= drcs_pkg::CTRL_RST;
      dirReg <= drcs_pkg::DIR_RST;
      autoReg <= drcs_pkg::AUTO_RST;
      linkCfgReg <= drcs_pkg::LINKCFG_RST;
      termFuncReg <= drcs_pkg::TERMFUNC_RST;
      linkRunReg <= '0;
    end else if (busWrite) begin
      unique case (wb_adr_i)
        drcs_pkg::REG_CTRL: ctrlReg <= wrMerged;
        drcs_pkg::REG_DIR: dirReg <= wrMerged;
        drcs_pkg::REG_AUTO: autoReg <= wrMerged;
        drcs_pkg::REG_LINKCFG: linkCfgReg <= wrMerged;
        drcs_pkg::REG_TERMFUNC: termFuncReg <= wrMerged;
        drcs_pkg::REG_LINKRUN: linkRunReg <= wrMerged;
        default: ;
      endcase
    end
  end

  // Step table port: bus owns the read address only while a request is open
  assign stepBus.wrEn = busWrite && stepHit;
  assign stepBus.wrAddr = wb_adr_i[drcs_pkg::STEP_AW+1:2];
  assign stepBus.wrData = wb_dat_i[drcs_pkg::STEP_DW-1:0];
  assign stepBus.rdAddr = (wb_cyc_i && wb_stb_i) ? wb_adr_i[drcs_pkg::STEP_AW+1:2]
                                                  : stepIndex;

  // Frequency command nonzero flag gates keypad start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      step0Set <= 1'b0;
    end else if (stepBus.wrEn && stepBus.wrAddr == '0) begin
      step0Set <= stepBus.wrData != '0;
    end
  end

  // Read data, captured with the ack
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (pend && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= '0;
      if (stepHit) begin
        wb_dat_o <= {{(32-drcs_pkg::STEP_DW){1'b0}}, stepBus.rdData};
      end else begin
        unique case (wb_adr_i)
          drcs_pkg::REG_CTRL: wb_dat_o <= ctrlReg;
          drcs_pkg::REG_DIR: wb_dat_o <= dirReg;
          drcs_pkg::REG_AUTO: wb_dat_o <= autoReg;
          drcs_pkg::REG_LINKCFG: wb_dat_o <= linkCfgReg;
          drcs_pkg::REG_TERMFUNC: wb_dat_o <= termFuncReg;
          drcs_pkg::REG_LINKRUN: wb_dat_o <= linkRunReg;
          drcs_pkg::REG_STATUS: begin
            wb_dat_o[0] <= runOut;
            wb_dat_o[drcs_pkg::ST_DIR] <= dirRevOut;
            wb_dat_o[drcs_pkg::ST_REVERSING] <= state == drcs_pkg::ST_REVERSE;
            wb_dat_o[drcs_pkg::ST_STEP_LSB +: drcs_pkg::STEP_AW] <= stepIndex;
            wb_dat_o[drcs_pkg::ST_NEED_EDGE] <= needEdge;
            wb_dat_o[drcs_pkg::ST_FAULT] <= faultActive;
          end
          default: ;
        endcase
      end
    end
  end

  // Keypad run latch; a remote keypad takes over the keys entirely
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keypadRun <= 1'b0;
    end else if (faultActive || cmdSource != drcs_pkg::SRC_KEYPAD) begin
      keypadRun <= 1'b0;
    end else if (remoteConnected) begin
      if (remoteStopKey) begin
        keypadRun <= 1'b0;
      end else if (remoteRunKey && step0Set) begin
        keypadRun <= 1'b1;
      end
    end else if (localStopKey) begin
      keypadRun <= 1'b0;
    end else if (localRunKey && step0Set) begin
      keypadRun <= 1'b1;
    end
  end

  // Power-up and fault-clear arming; terminal must cycle unless auto start applies
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      powerUp <= 1'b1;
      faultLast <= 1'b0;
      needEdge <= 1'b1;
    end else begin
      powerUp <= 1'b0;
      faultLast <= faultActive;
      if (powerUp) begin
        needEdge <= !(autoReg[0] && srcTerm && termRun);
      end else if (faultActive) begin
        needEdge <= 1'b1;
      end else if (faultLast) begin
        needEdge <= !(autoReg[drcs_pkg::AUTO_RESTART] && srcTerm && termRun);
      end else if (!termRun) begin
        needEdge <= 1'b0;
      end
    end
  end

  // Run state: a direction change passes through a full stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= drcs_pkg::ST_IDLE;
      runOut <= 1'b0;
      dirRevOut <= 1'b0;
    end else if (faultActive) begin
      state <= drcs_pkg::ST_IDLE;
      runOut <= 1'b0;
    end else begin
      unique case (state)
        drcs_pkg::ST_IDLE: begin
          if (wantRun && allowed) begin
            state <= drcs_pkg::ST_RUN;
            runOut <= 1'b1;
            dirRevOut <= wantRev;
          end
        end
        drcs_pkg::ST_RUN: begin
          if (!wantRun || !allowed) begin
            state <= drcs_pkg::ST_IDLE;
            runOut <= 1'b0;
          end else if (wantRev != dirRevOut) begin
            state <= drcs_pkg::ST_REVERSE;
            runOut <= 1'b0;
          end
        end
        drcs_pkg::ST_REVERSE: begin
          // Hold off until the ramp reports standstill
          if (!wantRun || !allowed) begin
            state <= drcs_pkg::ST_IDLE;
          end else if (motorStopped) begin
            state <= drcs_pkg::ST_RUN;
            runOut <= 1'b1;
            dirRevOut <= wantRev;
          end
        end
      endcase
    end
  end

  // Step index only while a run is requested and allowed, frequency follows when no bus request was open last cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stepIndex <= '0;
      busRdLast <= 1'b0;
      freqRef <= '0;
    end else begin
      stepIndex <= (wantRun && allowed) ? termStep : '0;
      busRdLast <= wb_cyc_i && wb_stb_i;
      if (!busRdLast) begin
        freqRef <= stepBus.rdData;
      end
    end
  end
endmodule // drcs_top

// ---- tb_drive_run_command_selector.sv ----
// Self-checking bench of the run command selector with scoreboard queues.
module tb_drive_run_command_selector;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, cyc, stb, we, ack, runOut, dirRev, stopped, sampleReq;
  logic remote, neg, fault, setRemote, setNeg, setFault;
  logic [7:0] adr, terminals, setTerm, station;
  logic [3:0] keys, setKeys, sel;
  logic [31:0] wdat, rdat;
  logic [2:0] step;
  logic [15:0] freq;
  logic [15:0] tbl [8];
  logic [31:0] rdQ [$];
  logic [20:0] runQ [$];
  int errCount, totalChecks, seed;

  // Clock at 250 MHz
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  drcs_top drcs_top_i (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .terminals(terminals),
    .localRunKey(keys[0]), .localStopKey(keys[1]), .remoteRunKey(keys[2]),
    .remoteStopKey(keys[3]), .remoteConnected(remote), .bipolarNegative(neg),
    .faultActive(fault), .motorStopped(stopped), .runOut(runOut), .dirRevOut(dirRev),
    .stepIndex(step), .freqRef(freq)
  );

  drcs_partner drcs_partner_i (
    .mclk(mclk), .rst(rst), .setTerm(setTerm), .setKeys(setKeys), .setRemote(setRemote),
    .setNeg(setNeg), .setFault(setFault), .runOut(runOut), .terminals(terminals),
    .keys(keys), .remoteConnected(remote), .bipolarNegative(neg), .faultActive(fault),
    .motorStopped(stopped)
  );

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Oldest note is matched against each result as it appears
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && rdQ.size() > 0)
      check("read data", rdat, rdQ.pop_front());
    if (sampleReq && runQ.size() > 0) begin
      if (runQ[0][20])
        check("run outputs", {11'h0, runOut, dirRev, step, freq}, {11'h0, runQ[0]});
      else
        check("run level", {31'h0, runOut}, 32'h0);
      void'(runQ.pop_front());
    end
  end

  // Classic single cycle; held until ack, released one cycle after
  task automatic wbCycle(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50) begin
      errCount++;
      conclude();
    end
    @(posedge mclk);
  endtask

  task automatic wbRead(logic [7:0] a, logic [31:0] exp);
    rdQ.push_back(exp);
    wbCycle(1'b0, a, 32'h0);
  endtask

  // Reversal may take a coast-down, so a run is awaited under a bound
  task automatic expectRun(logic r, logic d, logic [2:0] s);
    int n;
    n = 0;
    repeat (4) @(posedge mclk);
    while (r && runOut !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    if (n == 60) begin
      errCount++;
      conclude();
    end
    repeat (2) @(posedge mclk);
    runQ.push_back({r, d, s, tbl[s]});
    sampleReq <= 1'b1;
    @(posedge mclk);
    sampleReq <= 1'b0;
  endtask

  initial begin
    seed = 54806;
    {rst, cyc, stb, we, sampleReq} = 5'h10;
    {setRemote, setNeg, setFault, setKeys, setTerm} = 15'h0;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    errCount = 0;
    totalChecks = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values, unmapped place, link settings
    wbRead(drcs_pkg::REG_CTRL, drcs_pkg::CTRL_RST);
    wbRead(drcs_pkg::REG_DIR, drcs_pkg::DIR_RST);
    wbRead(drcs_pkg::REG_AUTO, drcs_pkg::AUTO_RST);
    wbRead(drcs_pkg::REG_LINKCFG, drcs_pkg::LINKCFG_RST);
    wbRead(drcs_pkg::REG_TERMFUNC, drcs_pkg::TERMFUNC_RST);
    wbCycle(1'b1, 8'h30, 32'hffff_ffff);
    wbRead(8'h30, 32'h0);
    wbCycle(1'b1, drcs_pkg::REG_TERMFUNC, 32'h0073_1420);
    station = 8'(($random(seed) & 127) + 1);
    wbCycle(1'b1, drcs_pkg::REG_LINKCFG, {13'h0, 3'h4, station, 8'h01});
    wbRead(drcs_pkg::REG_LINKCFG, {13'h0, 3'h4, station, 8'h01});
    // One byte lane only: the other lanes must keep their value
    sel <= 4'h2;
    wbCycle(1'b1, drcs_pkg::REG_LINKCFG, 32'hffff_33ff);
    sel <= 4'hf;
    wbRead(drcs_pkg::REG_LINKCFG, {13'h0, 3'h4, 8'h33, 8'h01});
    for (int i = 0; i < 8; i++) begin
      tbl[i] = 16'($random(seed)) | 16'h0001;
      wbCycle(1'b1, 8'(drcs_pkg::REG_STEP_BASE + 4 * i), {16'h0, tbl[i]});
    end
    // Source 1: every step index, both terminals, reversal
    for (int i = 0; i < 8; i++) begin
      setTerm <= {3'(i), 5'h01};
      expectRun(1'b1, 1'b0, 3'(i));
    end
    setTerm <= 8'h03;
    expectRun(1'b0, 1'b0, 3'h0);
    setTerm <= 8'h02;
    expectRun(1'b1, 1'b1, 3'h0);
    // Status word while running in reverse: run and direction bits only
    wbRead(drcs_pkg::REG_STATUS, 32'h0000_0003);
    setTerm <= 8'h01;
    expectRun(1'b1, 1'b0, 3'h0);
    // Run inhibit codes
    wbCycle(1'b1, drcs_pkg::REG_DIR, 32'h10);
    expectRun(1'b0, 1'b0, 3'h0);
    setTerm <= 8'h02;
    expectRun(1'b1, 1'b1, 3'h0);
    wbCycle(1'b1, drcs_pkg::REG_DIR, 32'h20);
    expectRun(1'b0, 1'b0, 3'h0);
    wbCycle(1'b1, drcs_pkg::REG_DIR, 32'h0);
    // Source 2: run plus direction select
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h2);
    setTerm <= 8'h01;
    expectRun(1'b1, 1'b0, 3'h0);
    setTerm <= 8'h03;
    expectRun(1'b1, 1'b1, 3'h0);
    // Bipolar reference inverts the commanded direction
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h21);
    setTerm <= 8'h01;
    setNeg <= 1'b1;
    expectRun(1'b1, 1'b1, 3'h0);
    setNeg <= 1'b0;
    expectRun(1'b1, 1'b0, 3'h0);
    setTerm <= 8'h02;
    setNeg <= 1'b1;
    expectRun(1'b1, 1'b0, 3'h0);
    setTerm <= 8'h00;
    setNeg <= 1'b0;
    // Keypad source, then remote keypad
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h0);
    wbCycle(1'b1, drcs_pkg::REG_DIR, 32'h1);
    setKeys <= 4'h1;
    expectRun(1'b1, 1'b1, 3'h0);
    setKeys <= 4'h2;
    expectRun(1'b0, 1'b0, 3'h0);
    setRemote <= 1'b1;
    setKeys <= 4'h1;
    expectRun(1'b0, 1'b0, 3'h0);
    setKeys <= 4'h4;
    expectRun(1'b1, 1'b1, 3'h0);
    setKeys <= 4'h8;
    expectRun(1'b0, 1'b0, 3'h0);
    setKeys <= 4'h0;
    setRemote <= 1'b0;
    // Serial link source
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h3);
    wbCycle(1'b1, drcs_pkg::REG_LINKRUN, 32'h3);
    expectRun(1'b1, 1'b1, 3'h0);
    wbCycle(1'b1, drcs_pkg::REG_LINKRUN, 32'h1);
    expectRun(1'b1, 1'b0, 3'h0);
    wbCycle(1'b1, drcs_pkg::REG_LINKRUN, 32'h0);
    // Fault clear without and with restart
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h1);
    setTerm <= 8'h01;
    expectRun(1'b1, 1'b0, 3'h0);
    setFault <= 1'b1;
    expectRun(1'b0, 1'b0, 3'h0);
    setFault <= 1'b0;
    expectRun(1'b0, 1'b0, 3'h0);
    setTerm <= 8'h00;
    expectRun(1'b0, 1'b0, 3'h0);
    setTerm <= 8'h01;
    expectRun(1'b1, 1'b0, 3'h0);
    wbCycle(1'b1, drcs_pkg::REG_AUTO, 32'h2);
    setFault <= 1'b1;
    expectRun(1'b0, 1'b0, 3'h0);
    setFault <= 1'b0;
    expectRun(1'b1, 1'b0, 3'h0);
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h3);
    setFault <= 1'b1;
    expectRun(1'b0, 1'b0, 3'h0);
    setFault <= 1'b0;
    expectRun(1'b0, 1'b0, 3'h0);
    // Back on terminals: the clear under the link source must not have armed a restart
    wbCycle(1'b1, drcs_pkg::REG_CTRL, 32'h1);
    expectRun(1'b0, 1'b0, 3'h0);
    // Second reset with the run terminal held on
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    expectRun(1'b0, 1'b0, 3'h0);
    // Power-on start off, so the terminal still has to cycle
    wbRead(drcs_pkg::REG_STATUS, 32'h0000_0100);
    conclude();
  end
endmodule // tb_drive_run_command_selector
